// ==== src/pcm_port_cd_mux.sv ====
// alternate-function override logic for ports c and d
`timescale 1ns/10ps
`default_nettype none
module pcm_port_cd_mux (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // port register settings
  input wire logic [7:0] portc_data,
  input wire logic [7:0] portc_dir,
  input wire logic [7:0] portd_data,
  input wire logic [7:0] portd_dir,
  input wire logic pullup_disable,
  // external memory
  input wire logic ext_mem_enable,
  input wire logic [2:0] ext_addr_mask_field,
  input wire logic [7:0] ext_addr_high,
  input wire logic ext_rd_strobe,
  input wire logic ext_wr_strobe,
  // test access port
  input wire logic test_port_enable,
  input wire logic tap_shift_ir,
  input wire logic tap_shift_dr,
  input wire logic tap_tdo,
  // pin change
  input wire logic pin_change_group_enable,
  input wire logic [7:0] pin_change_mask,
  // timers
  input wire logic timer2_async_select,
  input wire logic timer1_cmp_a_en,
  input wire logic timer1_cmp_a_out,
  input wire logic timer3_cmp_a_en,
  input wire logic timer3_cmp_a_out,
  // usarts
  input wire logic usart0_sync_mode,
  input wire logic usart0_clock_out,
  input wire logic usart1_sync_mode,
  input wire logic usart1_clock_out,
  input wire logic usart0_tx_en,
  input wire logic usart0_tx_pin,
  input wire logic usart0_rx_en,
  // external interrupts
  input wire logic ext_irq_0_en,
  input wire logic ext_irq_1_en,
  // pin levels
  input wire logic [7:0] portc_pin_in,
  input wire logic [7:0] portd_pin_in,
  // port c pin controls
  output logic [7:0] portc_out,
  output logic [7:0] portc_oe_n,
  output logic [7:0] portc_pullup,
  output logic [7:0] portc_input_en,
  // port d pin controls
  output logic [7:0] portd_out,
  output logic [7:0] portd_oe_n,
  output logic [7:0] portd_pullup,
  output logic [7:0] portd_input_en,
  // signals to peripherals
  output logic [15:8] pin_change_line,
  output logic test_clock_in,
  output logic test_mode_in,
  output logic test_data_in,
  output logic timer_osc_connect,
  output logic usart0_ext_clock_in,
  output logic usart1_ext_clock_in,
  output logic usart0_rx_pin,
  output logic ext_irq_0,
  output logic ext_irq_1,
  output logic timer3_capture_in
);
  pcm_ovr_if ovr_c ();
  pcm_ovr_if ovr_d ();
  logic tdo_drive;
  logic [7:0] claim_c;
  logic [2:0] m;
  logic usart0_clk_drive;
  logic usart1_clk_drive;
  logic [7:0] pc_in_reg;
  logic [7:0] pd_in_reg;
  assign m = ext_addr_mask_field;

  assign claim_c[7] = ext_mem_enable && (m < pcm_pkg::MASK_LIMIT_7);
  assign claim_c[6] = ext_mem_enable && (m < pcm_pkg::MASK_LIMIT_6);
  assign claim_c[5] = ext_mem_enable && (m < pcm_pkg::MASK_LIMIT_5);
  assign claim_c[4] = ext_mem_enable && (m < pcm_pkg::MASK_LIMIT_4);
  assign claim_c[3] = ext_mem_enable && (m < pcm_pkg::MASK_LIMIT_3);
  assign claim_c[2] = ext_mem_enable && (m < pcm_pkg::MASK_LIMIT_2);
  assign claim_c[1] = ext_mem_enable && (m < pcm_pkg::MASK_LIMIT_1);
  assign claim_c[0] = ext_mem_enable && (m < pcm_pkg::MASK_LIMIT_0);

  pcm_tdo_ctrl u_tdo (
    .clk(clk),
    .srst(srst),
    .test_port_enable(test_port_enable),
    .tap_shift_ir(tap_shift_ir),
    .tap_shift_dr(tap_shift_dr),
    .tdo_drive(tdo_drive)
  );

  // port c overrides
  always_comb begin
    // upper bits: test port also claims
    ovr_c.pullup_override_en[7:4] = claim_c[7:4] | {4{test_port_enable}};
    ovr_c.pullup_override_val[7:4] = {4{test_port_enable}};
    ovr_c.dir_override_en[7:4] = claim_c[7:4] | {4{test_port_enable}};
    ovr_c.dir_override_val[7:4] = {4{test_port_enable}};
    ovr_c.dir_override_val[pcm_pkg::TDO_BIT] = test_port_enable ? tdo_drive : 1'b1;
    ovr_c.dir_override_val[pcm_pkg::TDI_BIT] = 1'b0 | (~test_port_enable);
    ovr_c.dir_override_val[pcm_pkg::TMS_BIT] = ~test_port_enable;
    ovr_c.dir_override_val[pcm_pkg::TCK_BIT] = ~test_port_enable;
    ovr_c.pullup_override_val[pcm_pkg::TDO_BIT] = test_port_enable & ~tdo_drive;
    ovr_c.out_value_override_en[7:4] = claim_c[7:4];
    ovr_c.out_value_override_en[pcm_pkg::TDO_BIT] = claim_c[6] | test_port_enable;
    ovr_c.out_value_override_val = ext_addr_high;
    ovr_c.out_value_override_val[pcm_pkg::TDO_BIT] = test_port_enable ? tap_tdo : ext_addr_high[6];
    ovr_c.pullup_override_en[3:0] = claim_c[3:0];
    ovr_c.pullup_override_val[3:0] = 4'h0;
    ovr_c.dir_override_en[3:0] = claim_c[3:0];
    ovr_c.dir_override_val[3:0] = 4'hf;
    ovr_c.out_value_override_en[3:0] = claim_c[3:0];
    // input enable for pin change or test port
    ovr_c.input_en_override_en = (pin_change_mask & {8{pin_change_group_enable}})
                                 | {{4{test_port_enable}}, 4'h0};
    ovr_c.input_en_override_val = 8'hff;
  end

  // gating on the clock level itself would let the port bit show through on every low phase
  assign usart0_clk_drive = usart0_sync_mode & portd_dir[4];
  assign usart1_clk_drive = usart1_sync_mode & portd_dir[2];

  // port d overrides
  always_comb begin
    ovr_d.pullup_override_en = 8'h00;
    ovr_d.pullup_override_val = 8'h00;
    ovr_d.dir_override_en = 8'h00;
    ovr_d.dir_override_val = 8'h00;
    ovr_d.out_value_override_en = 8'h00;
    ovr_d.out_value_override_val = 8'h00;
    ovr_d.input_en_override_en = 8'h00;
    ovr_d.input_en_override_val = 8'h00;
    ovr_d.pullup_override_en[7] = ext_mem_enable;
    ovr_d.dir_override_en[7] = ext_mem_enable;
    ovr_d.dir_override_val[7] = 1'b1;
    ovr_d.out_value_override_en[7] = ext_mem_enable;
    ovr_d.out_value_override_val[7] = ext_rd_strobe;
    ovr_d.pullup_override_en[6] = ext_mem_enable;
    ovr_d.dir_override_en[6] = ext_mem_enable;
    ovr_d.dir_override_val[6] = 1'b1;
    ovr_d.out_value_override_en[6] = ext_mem_enable;
    ovr_d.out_value_override_val[6] = ext_wr_strobe;
    // compare a, pin direction gates it
    ovr_d.out_value_override_en[5] = timer1_cmp_a_en;
    ovr_d.out_value_override_val[5] = timer1_cmp_a_out;
    ovr_d.pullup_override_en[5] = timer2_async_select;
    ovr_d.dir_override_en[5] = timer2_async_select;
    ovr_d.input_en_override_en[5] = timer2_async_select;
    // usart0 clock out when sync and dir set
    ovr_d.out_value_override_en[4] = usart0_clk_drive | timer3_cmp_a_en;
    ovr_d.out_value_override_val[4] = usart0_clk_drive ? usart0_clock_out : timer3_cmp_a_out;
    ovr_d.pullup_override_en[4] = timer2_async_select;
    ovr_d.dir_override_en[4] = timer2_async_select;
    ovr_d.input_en_override_en[4] = timer2_async_select;
    ovr_d.input_en_override_en[3] = ext_irq_1_en;
    ovr_d.input_en_override_val[3] = 1'b1;
    ovr_d.out_value_override_en[2] = usart1_clk_drive;
    ovr_d.out_value_override_val[2] = usart1_clock_out;
    ovr_d.input_en_override_en[2] = ext_irq_0_en;
    ovr_d.input_en_override_val[2] = 1'b1;
    ovr_d.pullup_override_en[1] = usart0_tx_en;
    ovr_d.dir_override_en[1] = usart0_tx_en;
    ovr_d.dir_override_val[1] = 1'b1;
    ovr_d.out_value_override_en[1] = usart0_tx_en;
    ovr_d.out_value_override_val[1] = usart0_tx_pin;
    ovr_d.pullup_override_en[0] = usart0_rx_en;
    ovr_d.pullup_override_val[0] = portd_data[0] & ~pullup_disable;
    ovr_d.dir_override_en[0] = usart0_rx_en;
  end

  pcm_pin_apply u_port_c (
    .clk(clk),
    .srst(srst),
    .ovr(ovr_c),
    .port_data(portc_data),
    .port_dir(portc_dir),
    .pullup_disable(pullup_disable),
    .pin_out(portc_out),
    .pin_oe_n(portc_oe_n),
    .pin_pullup(portc_pullup),
    .pin_input_en(portc_input_en)
  );

  pcm_pin_apply u_port_d (
    .clk(clk),
    .srst(srst),
    .ovr(ovr_d),
    .port_data(portd_data),
    .port_dir(portd_dir),
    .pullup_disable(pullup_disable),
    .pin_out(portd_out),
    .pin_oe_n(portd_oe_n),
    .pin_pullup(portd_pullup),
    .pin_input_en(portd_input_en)
  );

  // registered pin inputs gated by input enable
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_in_reg <= pcm_pkg::PORT_RESET;
      pd_in_reg <= pcm_pkg::PORT_RESET;
    end else begin
      pc_in_reg <= portc_pin_in & portc_input_en;
      pd_in_reg <= portd_pin_in & portd_input_en;
    end
  end

  assign pin_change_line = pc_in_reg;
  assign test_clock_in = test_port_enable & pc_in_reg[pcm_pkg::TCK_BIT];
  assign test_mode_in = test_port_enable & pc_in_reg[pcm_pkg::TMS_BIT];
  assign test_data_in = test_port_enable & pc_in_reg[pcm_pkg::TDI_BIT];
  assign timer_osc_connect = timer2_async_select;
  assign usart0_ext_clock_in = usart0_sync_mode & ~portd_dir[4] & pd_in_reg[4];
  assign usart1_ext_clock_in = usart1_sync_mode & ~portd_dir[2] & pd_in_reg[2];
  assign usart0_rx_pin = pd_in_reg[0];
  assign ext_irq_0 = pd_in_reg[2];
  assign ext_irq_1 = pd_in_reg[3];
  assign timer3_capture_in = pd_in_reg[3];
endmodule
`default_nettype wire

// ==== src/pcm_pkg.sv ====
// constants for the port c/d alternate-function override logic
package pcm_pkg;
  localparam int PORT_WIDTH = 8;
  localparam logic [7:0] PORT_RESET = 8'h00;
  // mask thresholds for port c bits 7..0
  localparam logic [2:0] MASK_LIMIT_7 = 3'h1;
  localparam logic [2:0] MASK_LIMIT_6 = 3'h2;
  localparam logic [2:0] MASK_LIMIT_5 = 3'h3;
  localparam logic [2:0] MASK_LIMIT_4 = 3'h4;
  localparam logic [2:0] MASK_LIMIT_3 = 3'h5;
  localparam logic [2:0] MASK_LIMIT_2 = 3'h6;
  localparam logic [2:0] MASK_LIMIT_1 = 3'h7;
  localparam logic [2:0] MASK_LIMIT_0 = 3'h7;
  localparam int TCK_BIT = 4;
  localparam int TDO_BIT = 6;
  localparam int TMS_BIT = 5;
  localparam int TDI_BIT = 7;
  typedef enum logic [1:0] {
    PCM_TDO_IDLE_type_v = 2'b01,
    PCM_TDO_SHIFT_type_v = 2'b10
  } pcm_tdo_state_type;
endpackage

// ==== src/pcm_ovr_if.sv ====
// override bundle for one eight-bit port
`timescale 1ns/10ps
`default_nettype none
interface pcm_ovr_if;
  logic [7:0] pullup_override_en;
  logic [7:0] pullup_override_val;
  logic [7:0] dir_override_en;
  logic [7:0] dir_override_val;
  logic [7:0] out_value_override_en;
  logic [7:0] out_value_override_val;
  logic [7:0] input_en_override_en;
  logic [7:0] input_en_override_val;
  modport src (output pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
    output out_value_override_en, out_value_override_val, input_en_override_en, input_en_override_val);
  modport dst (input pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
    input out_value_override_en, out_value_override_val, input_en_override_en, input_en_override_val);
endinterface
`default_nettype wire

// ==== src/pcm_pin_apply.sv ====
// per-pin merge of override signals with port register settings
`timescale 1ns/10ps
`default_nettype none
module pcm_pin_apply (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // overrides
  pcm_ovr_if.dst ovr,
  // port register settings
  input wire logic [7:0] port_data,
  input wire logic [7:0] port_dir,
  input wire logic pullup_disable,
  // pin side
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] pin_pullup,
  output logic [7:0] pin_input_en
);
  logic [7:0] pin_out_reg;
  logic [7:0] pin_dir_reg;
  logic [7:0] pin_pullup_reg;
  logic [7:0] pin_ie_reg;
  logic [7:0] out_next;
  logic [7:0] dir_next;
  logic [7:0] pullup_next;
  logic [7:0] ie_next;
  genvar i;
  generate
    for (i = 0; i < pcm_pkg::PORT_WIDTH; i++) begin : g_pin
      assign dir_next[i] = ovr.dir_override_en[i] ? ovr.dir_override_val[i] : port_dir[i];
      assign out_next[i] = ovr.out_value_override_en[i] ? ovr.out_value_override_val[i] : port_data[i];
      assign pullup_next[i] = ovr.pullup_override_en[i] ? ovr.pullup_override_val[i]
                                                        : (port_data[i] & ~port_dir[i] & ~pullup_disable);
      assign ie_next[i] = ovr.input_en_override_en[i] ? ovr.input_en_override_val[i] : 1'b1;
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_out_reg <= pcm_pkg::PORT_RESET;
      pin_dir_reg <= pcm_pkg::PORT_RESET;
      pin_pullup_reg <= ovr.pullup_override_en & ovr.pullup_override_val;
      pin_ie_reg <= pcm_pkg::PORT_RESET;
    end else begin
      pin_out_reg <= out_next;
      pin_dir_reg <= dir_next;
      pin_pullup_reg <= pullup_next;
      pin_ie_reg <= ie_next;
    end
  end
  assign pin_out = pin_out_reg;
  // enable is active low while driving
  assign pin_oe_n = ~pin_dir_reg;
  assign pin_pullup = pin_pullup_reg;
  assign pin_input_en = pin_ie_reg;
endmodule
`default_nettype wire

// ==== src/pcm_tdo_ctrl.sv ====
// test data output drive control
`timescale 1ns/10ps
`default_nettype none
module pcm_tdo_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // test controller
  input wire logic test_port_enable,
  input wire logic tap_shift_ir,
  input wire logic tap_shift_dr,
  // result
  output logic tdo_drive
);
  pcm_pkg::pcm_tdo_state_type state_reg;
  pcm_pkg::pcm_tdo_state_type state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pcm_pkg::PCM_TDO_IDLE_type_v: begin
        if (test_port_enable && (tap_shift_ir || tap_shift_dr)) begin
          state_next = pcm_pkg::PCM_TDO_SHIFT_type_v;
        end
      end
      pcm_pkg::PCM_TDO_SHIFT_type_v: begin
        if (!(test_port_enable && (tap_shift_ir || tap_shift_dr))) begin
          state_next = pcm_pkg::PCM_TDO_IDLE_type_v;
        end
      end
      default: begin
        state_next = pcm_pkg::PCM_TDO_IDLE_type_v;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= pcm_pkg::PCM_TDO_IDLE_type_v;
    end else begin
      state_reg <= state_next;
    end
  end
  assign tdo_drive = (state_reg == pcm_pkg::PCM_TDO_SHIFT_type_v);
endmodule
`default_nettype wire

// ==== verif/pcm_port_cd_mux_props.sv ====
// assertion checker for the port c/d override logic
`timescale 1ns/10ps
`default_nettype none
module pcm_port_cd_mux_props (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // controls
  input wire logic [7:0] portc_dir,
  input wire logic [7:0] portd_data,
  input wire logic [7:0] portd_dir,
  input wire logic pullup_disable,
  input wire logic ext_mem_enable,
  input wire logic [2:0] ext_addr_mask_field,
  input wire logic [7:0] ext_addr_high,
  input wire logic ext_rd_strobe,
  input wire logic ext_wr_strobe,
  input wire logic test_port_enable,
  input wire logic tap_shift_dr,
  input wire logic timer2_async_select,
  input wire logic timer1_cmp_a_en,
  input wire logic usart0_tx_en,
  input wire logic usart0_tx_pin,
  input wire logic usart0_rx_en,
  // pin controls
  input wire logic [7:0] portc_out,
  input wire logic [7:0] portc_oe_n,
  input wire logic [7:0] portc_pullup,
  input wire logic [7:0] portd_out,
  input wire logic [7:0] portd_oe_n,
  input wire logic [7:0] portd_pullup,
  input wire logic [7:0] portd_input_en,
  input wire logic timer_osc_connect
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_addr_full_drive: assert property (
    ext_mem_enable && ext_addr_mask_field == 3'h0 && !test_port_enable
    |=> portc_oe_n == 8'h00 && portc_out == $past(ext_addr_high)) else $error("address not on port c");
  a_mask_split: assert property (
    ext_mem_enable && ext_addr_mask_field == 3'h4 && !test_port_enable |=> portc_oe_n[3:0] == 4'h0
    && portc_pullup[3:0] == 4'h0 && portc_oe_n[7:4] == ~$past(portc_dir[7:4])) else $error("mask split wrong");
  a_read_strobe: assert property (
    ext_mem_enable |=> !portd_oe_n[7] && portd_out[7] == $past(ext_rd_strobe)) else $error("read strobe lost");
  a_write_strobe: assert property (
    ext_mem_enable |=> !portd_oe_n[6] && portd_out[6] == $past(ext_wr_strobe)) else $error("write strobe lost");
  a_osc_release: assert property (
    timer2_async_select |=> portd_oe_n[5:4] == 2'b11 && portd_pullup[5:4] == 2'b00
    && portd_input_en[5:4] == 2'b00) else $error("oscillator pins not released");
  a_osc_connect: assert property (
    timer_osc_connect == timer2_async_select) else $error("oscillator connect wrong");
  a_cmp_gate: assert property (
    timer1_cmp_a_en && !portd_dir[5] && !timer2_async_select |=> portd_oe_n[5]) else $error("compare leaked");
  a_tx_force: assert property (
    usart0_tx_en |=> !portd_oe_n[1] && !portd_pullup[1] && portd_out[1] == $past(usart0_tx_pin))
    else $error("transmit pin not forced");
  a_rx_force: assert property (
    usart0_rx_en |=> portd_oe_n[0] && portd_pullup[0] == ($past(portd_data[0]) && !$past(pullup_disable)))
    else $error("receive pin not forced");
  a_test_pins_held: assert property (
    test_port_enable |=> (portc_oe_n & 8'hb0) == 8'hb0 && (portc_pullup & 8'hb0) == 8'hb0)
    else $error("test pins not held");
  a_tdo_drive: assert property (
    (test_port_enable && tap_shift_dr) [*3] |-> !portc_oe_n[6]) else $error("test data out not driven");
  c_mask_top: cover property (ext_mem_enable && ext_addr_mask_field == 3'h7);
  c_shift: cover property (test_port_enable && tap_shift_dr);
  c_usart: cover property (usart0_tx_en && usart0_rx_en);
endmodule
bind pcm_port_cd_mux pcm_port_cd_mux_props u_props (.*);
`default_nettype wire

// ==== verif/pcm_pin_model.sv ====
// far-side pin model: device drive, outside drivers, pull-ups
`timescale 1ns/10ps
`default_nettype none
module pcm_pin_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe_n,
  input wire logic [7:0] dev_pullup,
  // outside drivers
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_val,
  // resolved level
  output logic [7:0] pin
);
  logic [7:0] float_reg = 8'h00;
  // a floating pin wanders, so a stale level never passes for a driven one
  always_ff @(posedge clk) begin
    float_reg <= ~pin;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!dev_oe_n[i]) begin
        pin[i] = dev_out[i];
      end else if (ext_drv[i]) begin
        pin[i] = ext_val[i];
      end else begin
        pin[i] = dev_pullup[i] | float_reg[i];
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_port_cd_alt_function_mux.sv ====
// self-checking bench for the port c/d override logic
`timescale 1ns/10ps
`default_nettype none
module tb_port_cd_alt_function_mux;
  logic clk, srst, pullup_disable, ext_mem_enable, ext_rd_strobe, ext_wr_strobe;
  logic [7:0] portc_data, portc_dir, portd_data, portd_dir, ext_addr_high, pin_change_mask;
  logic [2:0] ext_addr_mask_field;
  logic test_port_enable, tap_shift_ir, tap_shift_dr, tap_tdo, pin_change_group_enable;
  logic timer2_async_select, timer1_cmp_a_en, timer1_cmp_a_out, timer3_cmp_a_en, timer3_cmp_a_out;
  logic usart0_sync_mode, usart0_clock_out, usart1_sync_mode, usart1_clock_out;
  logic usart0_tx_en, usart0_tx_pin, usart0_rx_en, ext_irq_0_en, ext_irq_1_en;
  logic [7:0] portc_pin_in, portd_pin_in, portc_out, portc_oe_n, portc_pullup, portc_input_en;
  logic [7:0] portd_out, portd_oe_n, portd_pullup, portd_input_en, c_drv, c_val, d_drv, d_val, ov;
  logic [15:8] pin_change_line;
  logic test_clock_in, test_mode_in, test_data_in, timer_osc_connect, usart0_ext_clock_in;
  logic usart1_ext_clock_in, usart0_rx_pin, ext_irq_0, ext_irq_1, timer3_capture_in;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  // mask limit per port c bit, index is the bit
  int lim [8] = '{7, 7, 6, 5, 4, 3, 2, 1};
  pcm_port_cd_mux DUT (.*);
  pcm_pin_model u_pc (.clk(clk), .dev_out(portc_out), .dev_oe_n(portc_oe_n), .dev_pullup(portc_pullup),
    .ext_drv(c_drv), .ext_val(c_val), .pin(portc_pin_in));
  pcm_pin_model u_pd (.clk(clk), .dev_out(portd_out), .dev_oe_n(portd_oe_n), .dev_pullup(portd_pullup),
    .ext_drv(d_drv), .ext_val(d_val), .pin(portd_pin_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // pin controls lag one cycle and samples one more, so four edges is ample
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    srst = 1'b1;
    {portc_data, portc_dir, portd_data, portd_dir, pullup_disable, ext_mem_enable, ext_addr_mask_field,
      ext_addr_high, ext_rd_strobe, ext_wr_strobe, test_port_enable, tap_shift_ir, tap_shift_dr, tap_tdo,
      pin_change_group_enable, pin_change_mask, timer2_async_select, timer1_cmp_a_en, timer1_cmp_a_out,
      timer3_cmp_a_en, timer3_cmp_a_out, usart0_sync_mode, usart0_clock_out, usart1_sync_mode,
      usart1_clock_out, usart0_tx_en, usart0_tx_pin, usart0_rx_en, ext_irq_0_en, ext_irq_1_en,
      c_drv, c_val, d_drv, d_val} = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    portc_dir <= 8'hf0;
    portc_data <= 8'ha5;
    portd_dir <= 8'h3c;
    portd_data <= 8'hc3;
    settle();
    chk(portc_oe_n, 8'h0f);
    chk(portc_out, 8'ha5);
    chk(portc_pullup, 8'h05);
    chk(portd_pullup, 8'hc3);
    chk(portd_input_en, 8'hff);
    @(posedge clk);
    pullup_disable <= 1'b1;
    settle();
    chk(portd_pullup, 8'h00);
    @(posedge clk);
    pullup_disable <= 1'b0;
    portc_dir <= 8'h00;
    ext_mem_enable <= 1'b1;
    ext_addr_high <= 8'h5a;
    ext_rd_strobe <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      ext_addr_mask_field <= 3'(m);
      settle();
      for (int i = 0; i < 8; i++) begin
        ov[i] = (m < lim[i]);
      end
      chk(portc_oe_n, ~ov);
      chk(portc_out, (ov & 8'h5a) | (~ov & 8'ha5));
      chk(portc_pullup, ~ov & 8'ha5);
      chk({portd_oe_n[7:6], portd_out[7:6]}, 8'h02);
    end
    @(posedge clk);
    ext_mem_enable <= 1'b0;
    portc_dir <= 8'h00;
    c_drv <= 8'hff;
    c_val <= 8'h1e;
    pin_change_group_enable <= 1'b1;
    pin_change_mask <= 8'hff;
    settle();
    chk(pin_change_line, 8'h1e);
    chk(portc_input_en, 8'hff);
    @(posedge clk);
    c_val <= 8'h90;
    test_port_enable <= 1'b1;
    tap_shift_dr <= 1'b1;
    tap_tdo <= 1'b1;
    settle();
    chk(portc_oe_n & 8'hb0, 8'hb0);
    chk(portc_pullup & 8'hb0, 8'hb0);
    chk({test_data_in, test_mode_in, test_clock_in}, 8'h05);
    chk({portc_oe_n[6], portc_out[6]}, 8'h01);
    @(posedge clk);
    tap_shift_dr <= 1'b0;
    settle();
    chk(portc_oe_n[6] ? portc_pullup[6] : portc_out[6], 8'h01);
    @(posedge clk);
    tap_shift_ir <= 1'b1;
    tap_tdo <= 1'b0;
    settle();
    chk({portc_oe_n[6], portc_out[6]}, 8'h00);
    @(posedge clk);
    srst <= 1'b1;
    settle();
    chk(portc_pullup & 8'hb0, 8'hb0);
    @(posedge clk);
    srst <= 1'b0;
    test_port_enable <= 1'b0;
    tap_shift_ir <= 1'b0;
    portd_dir <= 8'hff;
    portd_data <= 8'h20;
    timer2_async_select <= 1'b1;
    timer1_cmp_a_en <= 1'b1;
    timer3_cmp_a_en <= 1'b1;
    timer3_cmp_a_out <= 1'b1;
    settle();
    chk({portd_oe_n[5:4], portd_pullup[5:4], portd_input_en[5:4]}, 8'h30);
    chk(timer_osc_connect, 8'h01);
    @(posedge clk);
    timer2_async_select <= 1'b0;
    settle();
    chk({portd_oe_n[5:4], portd_out[5:4]}, 8'h01);
    @(posedge clk);
    portd_dir <= 8'hcf;
    settle();
    chk(portd_oe_n[5:4], 8'h03);
    @(posedge clk);
    timer1_cmp_a_en <= 1'b0;
    timer3_cmp_a_en <= 1'b0;
    portd_dir <= 8'h01;
    portd_data <= 8'h01;
    usart0_tx_en <= 1'b1;
    usart0_tx_pin <= 1'b1;
    usart0_rx_en <= 1'b1;
    ext_irq_0_en <= 1'b1;
    ext_irq_1_en <= 1'b1;
    usart1_sync_mode <= 1'b1;
    usart0_sync_mode <= 1'b1;
    d_drv <= 8'h1d;
    settle();
    chk({portd_oe_n[1:0], portd_out[1], portd_pullup[0]}, 8'h07);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      d_val <= {3'h0, 1'(v), 1'(v), 1'(v), 1'b0, 1'(v)};
      settle();
      chk({ext_irq_1, timer3_capture_in}, {2{1'(v)}});
      chk({ext_irq_0, usart1_ext_clock_in, usart0_ext_clock_in, usart0_rx_pin}, {4{1'(v)}});
    end
    @(posedge clk);
    d_drv <= 8'h00;
    portd_dir <= 8'h14;
    portd_data <= 8'h00;
    usart0_sync_mode <= 1'b1;
    usart0_clock_out <= 1'b1;
    usart1_clock_out <= 1'b1;
    settle();
    chk({portd_oe_n[4], portd_out[4], portd_oe_n[2], portd_out[2]}, 8'h05);
    @(posedge clk);
    usart0_clock_out <= 1'b0;
    usart1_clock_out <= 1'b0;
    portd_data <= 8'h14;
    settle();
    chk({portd_oe_n[4], portd_out[4], portd_oe_n[2], portd_out[2]}, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
